/* inc/frt_pkg.sv */
// Package of constants and carrier types for the fault, tracking and margin supervisor.
package frt_pkg;

  localparam int CLK_MHZ = 40;
  // Retry delay between restart attempts, in microseconds.
  localparam int RETRY_DELAY_US = 100;
  localparam int RETRY_DELAY_CYC = RETRY_DELAY_US * CLK_MHZ;
  // Run-on delay before a delayed shutdown, in microseconds.
  localparam int RUNON_DELAY_US = 50;
  localparam int RUNON_DELAY_CYC = RUNON_DELAY_US * CLK_MHZ;
  localparam logic [3:0] RETRY_COUNT_RST = 4'h3;

  localparam logic signed [8:0] TEMP_LIMIT_RST = 9'sh07D;
  localparam logic [7:0] TEMP_HYST = 8'h0F;
  localparam logic [6:0] TRACK_RATIO_RST = 7'h32;
  localparam logic [6:0] TRACK_RATIO_FULL = 7'h64;
  localparam logic [6:0] TRACK_RATIO_HALF = 7'h32;
  localparam logic [4:0] MARGIN_PCT_RST = 5'h05;
  localparam logic [4:0] MARGIN_PCT_MAX = 5'h0A;
  localparam logic [7:0] MARGIN_RATE_RST = 8'h01;

  typedef enum logic [2:0] {
    RESP_RETRY_FOREVER = 3'h0,
    RESP_RETRY_COUNT = 3'h1,
    RESP_DELAY_OFF = 3'h2,
    RESP_IGNORE = 3'h3,
    RESP_SHUTDOWN = 3'h4
  } frt_resp_type;

  typedef enum logic [1:0] {
    MGN_NOMINAL = 2'h0,
    MGN_LOW = 2'h1,
    MGN_HIGH = 2'h2
  } frt_margin_type;

  typedef struct packed {
    frt_resp_type resp;
    logic [3:0] retries;
  } frt_fault_cfg_type;

  typedef struct packed {
    logic enable;
    logic ratiometric;
    logic [6:0] ratio;
    logic limit_by_ref;
    logic follow_always;
  } frt_track_cfg_type;

  typedef struct packed {
    logic [4:0] high_pct;
    logic [4:0] low_pct;
    logic low_to_zero;
    logic [7:0] rate;
  } frt_margin_cfg_type;

endpackage

/* rtl/frt_supervisor.sv */
// Fault response, tracking configuration and margin control supervisor.
`timescale 1ns/1ps
`default_nettype none
module frt_supervisor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic oc_fault,
  input wire logic signed [8:0] die_temp,
  input wire frt_pkg::frt_fault_cfg_type oc_cfg,
  input wire frt_pkg::frt_fault_cfg_type ot_cfg,
  input wire logic temp_limit_wr,
  input wire logic signed [8:0] temp_limit_in,
  input wire logic restart_cmd,
  input wire logic [2:0] ss_strap_code,
  input wire logic track_cfg_wr,
  input wire frt_pkg::frt_track_cfg_type track_cfg_in,
  input wire logic [1:0] margin_select,
  input wire logic margin_cmd_wr,
  input wire frt_pkg::frt_margin_type margin_cmd_in,
  input wire logic margin_cmd_release,
  input wire logic margin_limit_wr,
  input wire frt_pkg::frt_margin_cfg_type margin_limit_in,
  input wire logic alert_clear,
  output logic output_enable,
  output logic use_softstart,
  output frt_pkg::frt_track_cfg_type track_cfg,
  output frt_pkg::frt_margin_type margin_active,
  output frt_pkg::frt_margin_cfg_type margin_cfg,
  output logic signed [8:0] temp_limit,
  output logic oc_latched_off,
  output logic ot_latched_off,
  output logic bus_alert_out
);
  import frt_pkg::*;

  typedef enum logic [3:0] {
    FS_RUN = 4'b0001,
    FS_RUNON = 4'b0010,
    FS_OFF = 4'b0100,
    FS_LATCH = 4'b1000
  } frt_fstate_type;

  typedef struct packed {
    frt_fstate_type st;
    logic [17:0] cnt;
    logic [3:0] tries;
  } frt_fault_type;

  typedef struct packed {
    frt_fault_type oc;
    frt_fault_type ot;
    logic signed [8:0] limit;
    frt_track_cfg_type trk;
    logic cmd_owns_margin;
    frt_margin_type cmd_margin;
    frt_margin_cfg_type mcfg;
    logic alert;
    logic [2:0] strap_seen;
  } frt_state_type;

  frt_state_type cur_ff;
  frt_state_type nxt_ff;

  logic ot_over;
  logic ot_cool;
  logic signed [9:0] cool_thr;

  // One response machine serves both faults, so the five behaviours match.
  function automatic frt_fault_type step_fault(frt_fault_type f,
      frt_fault_cfg_type cfg, logic flt, logic ok, logic cmd);
    frt_fault_type n;
    n = f;
    unique case (f.st)
      FS_RUN: begin
        if (flt) begin
          unique case (cfg.resp)
            RESP_IGNORE: n.st = FS_RUN;
            RESP_DELAY_OFF: begin
              n.st = FS_RUNON;
              n.cnt = 18'(RUNON_DELAY_CYC);
            end
            RESP_RETRY_COUNT: begin
              n.st = FS_OFF;
              n.cnt = 18'(RETRY_DELAY_CYC);
              n.tries = cfg.retries;
            end
            RESP_RETRY_FOREVER: begin
              n.st = FS_OFF;
              n.cnt = 18'(RETRY_DELAY_CYC);
            end
            default: begin
              n.st = FS_OFF;
              n.cnt = 18'h00000;
            end
          endcase
        end
      end
      FS_RUNON: begin
        if (!flt) begin
          n.st = FS_RUN;
        end else if (f.cnt == 18'h00000) begin
          n.st = FS_LATCH;
        end else begin
          n.cnt = f.cnt - 18'h00001;
        end
      end
      FS_OFF: begin
        if (f.cnt != 18'h00000) begin
          n.cnt = f.cnt - 18'h00001;
        end else if (ok) begin
          n.st = FS_RUN;
        end else if (cfg.resp == RESP_RETRY_COUNT) begin
          if (f.tries == 4'h0) begin
            n.st = FS_LATCH;
          end else begin
            n.tries = f.tries - 4'h1;
            n.cnt = 18'(RETRY_DELAY_CYC);
          end
        end else if (cfg.resp == RESP_RETRY_FOREVER) begin
          n.cnt = 18'(RETRY_DELAY_CYC);
        end
      end
      FS_LATCH: begin
        if (cmd) begin
          n.st = FS_RUN;
        end
      end
      default: n.st = FS_OFF;
    endcase
    return n;
  endfunction

  assign ot_over = die_temp > cur_ff.limit;
  // Both operands are signed so a negative limit keeps its sign.
  assign cool_thr = 10'(cur_ff.limit) - signed'(10'(TEMP_HYST));
  assign ot_cool = 10'(die_temp) <= cool_thr;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.oc = step_fault(cur_ff.oc, oc_cfg, oc_fault, !oc_fault,
                           restart_cmd);
    nxt_ff.ot = step_fault(cur_ff.ot, ot_cfg, ot_over, ot_cool,
                           restart_cmd);
    if (temp_limit_wr) begin
      nxt_ff.limit = temp_limit_in;
    end
    // The strap is sampled on every change so a late-settling pin still wins.
    nxt_ff.strap_seen = ss_strap_code;
    if (ss_strap_code != cur_ff.strap_seen) begin
      nxt_ff.trk.ratio = ss_strap_code[2] ? TRACK_RATIO_HALF
                                          : TRACK_RATIO_FULL;
      nxt_ff.trk.ratiometric = ss_strap_code[2];
      nxt_ff.trk.limit_by_ref = ss_strap_code[1];
      nxt_ff.trk.follow_always = ss_strap_code[0];
    end
    if (track_cfg_wr) begin
      nxt_ff.trk = track_cfg_in;
    end
    if (margin_cmd_wr) begin
      nxt_ff.cmd_owns_margin = 1'b1;
      nxt_ff.cmd_margin = margin_cmd_in;
    end else if (margin_cmd_release) begin
      nxt_ff.cmd_owns_margin = 1'b0;
    end
    if (margin_limit_wr) begin
      nxt_ff.mcfg = margin_limit_in;
      if (margin_limit_in.high_pct > MARGIN_PCT_MAX) begin
        nxt_ff.mcfg.high_pct = MARGIN_PCT_MAX;
      end
      if (margin_limit_in.low_pct > MARGIN_PCT_MAX) begin
        nxt_ff.mcfg.low_pct = MARGIN_PCT_MAX;
      end
    end
    // A new fault entry wins over a clear in the same cycle.
    if (alert_clear) begin
      nxt_ff.alert = 1'b0;
    end
    if ((cur_ff.oc.st == FS_RUN && oc_fault) ||
        (cur_ff.ot.st == FS_RUN && ot_over)) begin
      nxt_ff.alert = 1'b1;
    end
    if (rst) begin
      nxt_ff.oc = '{st: FS_RUN, cnt: 18'h00000, tries: 4'h0};
      nxt_ff.ot = '{st: FS_RUN, cnt: 18'h00000, tries: 4'h0};
      nxt_ff.limit = TEMP_LIMIT_RST;
      nxt_ff.trk = '{enable: 1'b0, ratiometric: 1'b1,
                     ratio: TRACK_RATIO_RST, limit_by_ref: 1'b0,
                     follow_always: 1'b0};
      nxt_ff.cmd_owns_margin = 1'b0;
      nxt_ff.cmd_margin = MGN_NOMINAL;
      nxt_ff.mcfg = '{high_pct: MARGIN_PCT_RST, low_pct: MARGIN_PCT_RST,
                      low_to_zero: 1'b0, rate: MARGIN_RATE_RST};
      nxt_ff.alert = 1'b0;
      nxt_ff.strap_seen = ss_strap_code;
    end
  end

  always_ff @(posedge mclk) begin
    cur_ff <= nxt_ff;
  end

  // The pin code 2'b11 is the floating level and means nominal.
  always_comb begin
    if (cur_ff.cmd_owns_margin) begin
      margin_active = cur_ff.cmd_margin;
    end else if (margin_select == 2'b10) begin
      margin_active = MGN_HIGH;
    end else if (margin_select == 2'b01) begin
      margin_active = MGN_LOW;
    end else begin
      margin_active = MGN_NOMINAL;
    end
  end

  assign output_enable = (cur_ff.oc.st inside {FS_RUN, FS_RUNON}) &&
                         (cur_ff.ot.st inside {FS_RUN, FS_RUNON});
  assign use_softstart = !cur_ff.trk.enable;
  assign track_cfg = cur_ff.trk;
  assign margin_cfg = cur_ff.mcfg;
  assign temp_limit = cur_ff.limit;
  assign oc_latched_off = cur_ff.oc.st == FS_LATCH;
  assign ot_latched_off = cur_ff.ot.st == FS_LATCH;
  assign bus_alert_out = cur_ff.alert;

  property p_ot_off;
    @(posedge mclk) disable iff (rst)
      (cur_ff.ot.st == FS_RUN && ot_over && ot_cfg.resp == RESP_SHUTDOWN)
      |=> !output_enable;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("no thermal shutdown");

  sequence s_oc_trip;
    cur_ff.oc.st == FS_RUN && oc_fault && oc_cfg.resp == RESP_SHUTDOWN;
  endsequence

  sequence s_oc_gone;
    !oc_fault && oc_cfg.resp == RESP_SHUTDOWN && !restart_cmd;
  endsequence

  property p_oc_off;
    @(posedge mclk) disable iff (rst)
      s_oc_trip |=> !output_enable;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("oc shutdown wrong");

  property p_oc_back;
    @(posedge mclk) disable iff (rst)
      s_oc_trip ##1 s_oc_gone |=> cur_ff.oc.st == FS_RUN;
  endproperty
  a_oc_back: assert property (p_oc_back) else $error("no oc re-enable");

  property p_oc_ignore;
    @(posedge mclk) disable iff (rst)
      (cur_ff.oc.st == FS_RUN && cur_ff.ot.st == FS_RUN &&
       oc_cfg.resp == RESP_IGNORE && !ot_over && !restart_cmd)
      |=> $stable(output_enable);
  endproperty
  a_oc_ignore: assert property (p_oc_ignore) else $error("ignore lost");

  property p_ot_hot_stay;
    @(posedge mclk) disable iff (rst)
      (cur_ff.ot.st == FS_OFF && cur_ff.ot.cnt == 18'h00000 && !ot_cool)
      |=> cur_ff.ot.st != FS_RUN;
  endproperty
  a_ot_hot_stay: assert property (p_ot_hot_stay) else $error("hot restart");

  property p_latch_hold;
    @(posedge mclk) disable iff (rst)
      (oc_latched_off && !restart_cmd) |=> oc_latched_off;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch left");

  property p_track_wr;
    @(posedge mclk) disable iff (rst)
      track_cfg_wr |=> track_cfg == $past(track_cfg_in);
  endproperty
  a_track_wr: assert property (p_track_wr) else $error("track cfg lost");

  property p_softstart;
    @(posedge mclk) disable iff (rst)
      track_cfg_wr && track_cfg_in.enable |=> !use_softstart;
  endproperty
  a_softstart: assert property (p_softstart) else $error("ss used");

  property p_margin_cap;
    @(posedge mclk) disable iff (rst)
      margin_limit_wr |=> margin_cfg.high_pct <= MARGIN_PCT_MAX &&
                          margin_cfg.low_pct <= MARGIN_PCT_MAX;
  endproperty
  a_margin_cap: assert property (p_margin_cap) else $error("margin cap");

  property p_alert;
    @(posedge mclk) disable iff (rst)
      (cur_ff.oc.st == FS_RUN && oc_fault) |=> bus_alert_out;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");

endmodule // frt_supervisor
`default_nettype wire

/* dv/frt_load_model.sv */
// Behavioural model of the load and die sensor beside the supervisor.
`timescale 1ns/1ps
`default_nettype none
module frt_load_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic short_req,
  input wire logic signed [8:0] temp_req,
  output logic oc_fault,
  output logic signed [8:0] die_temp
);
  // The fault stays present while the short is applied, whether or not the
  // output runs, so retries see a persistent condition.
  always_ff @(posedge mclk) begin
    if (rst) begin
      oc_fault <= 1'b0;
      die_temp <= 9'sh019;
    end else begin
      oc_fault <= short_req;
      die_temp <= temp_req;
    end
  end
endmodule // frt_load_model
`default_nettype wire

/* dv/fault_response_track_margin_ctl_bench.sv */
// Self-checking bench for the fault, tracking and margin supervisor.
`timescale 1ns/1ps
`default_nettype none
module fault_response_track_margin_ctl_bench;
  import frt_pkg::*;
  logic mclk, rst, oc_fault, temp_limit_wr, restart_cmd, track_cfg_wr;
  logic margin_cmd_wr, margin_cmd_release, margin_limit_wr, alert_clear;
  logic short_req, output_enable, use_softstart, oc_latched_off;
  logic ot_latched_off, bus_alert_out;
  logic signed [8:0] die_temp, temp_req, temp_limit_in, temp_limit;
  logic [2:0] ss_strap_code;
  logic [1:0] margin_select;
  frt_fault_cfg_type oc_cfg, ot_cfg;
  frt_track_cfg_type track_cfg_in, track_cfg;
  frt_margin_type margin_cmd_in, margin_active;
  frt_margin_cfg_type margin_limit_in, margin_cfg;
  int mismatches = 0;
  int compares = 0;
  frt_load_model load (.mclk(mclk), .rst(rst), .short_req(short_req),
    .temp_req(temp_req), .oc_fault(oc_fault), .die_temp(die_temp));
  frt_supervisor dut (.mclk(mclk), .rst(rst), .oc_fault(oc_fault),
    .die_temp(die_temp), .oc_cfg(oc_cfg), .ot_cfg(ot_cfg),
    .temp_limit_wr(temp_limit_wr), .temp_limit_in(temp_limit_in),
    .restart_cmd(restart_cmd), .ss_strap_code(ss_strap_code),
    .track_cfg_wr(track_cfg_wr), .track_cfg_in(track_cfg_in),
    .margin_select(margin_select), .margin_cmd_wr(margin_cmd_wr),
    .margin_cmd_in(margin_cmd_in), .margin_cmd_release(margin_cmd_release),
    .margin_limit_wr(margin_limit_wr), .margin_limit_in(margin_limit_in),
    .alert_clear(alert_clear), .output_enable(output_enable),
    .use_softstart(use_softstart), .track_cfg(track_cfg),
    .margin_active(margin_active), .margin_cfg(margin_cfg),
    .temp_limit(temp_limit), .oc_latched_off(oc_latched_off),
    .ot_latched_off(ot_latched_off), .bus_alert_out(bus_alert_out));
  always #12.5 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Waits a bounded span for output_enable (sel 0) or the latch (sel 1).
  task automatic wait_for(input int sel, input logic v, input int max);
    int i;
    i = 0;
    while ((sel ? oc_latched_off : output_enable) !== v && i < max) begin
      tick(1);
      i++;
    end
    chk(sel ? oc_latched_off : output_enable, v);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic stop_test;
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    // The tests need about 40k cycles; the margin still ends a hang early.
    repeat (60000) @(posedge mclk);
    mismatches++;
    stop_test;
  end
  initial begin
    mclk = 0;
    rst = 1;
    short_req = 0;
    temp_req = 9'sh019;
    temp_limit_wr = 0;
    // No hardware enable is modelled: a latched-off output restarts only by command.
    restart_cmd = 0;
    track_cfg_wr = 0;
    margin_cmd_wr = 0;
    margin_cmd_release = 0;
    margin_limit_wr = 0;
    alert_clear = 0;
    temp_limit_in = 9'sh000;
    ss_strap_code = 3'h4;
    margin_select = 2'h0;
    oc_cfg = '{RESP_SHUTDOWN, 4'h0};
    ot_cfg = '{RESP_SHUTDOWN, 4'h0};
    // The tracked rail's on-delay belongs to the system around this block.
    track_cfg_in = '{1'b1, 1'b0, 7'h64, 1'b0, 1'b1};
    margin_cmd_in = MGN_NOMINAL;
    margin_limit_in = '{5'h0C, 5'h03, 1'b0, 8'h07};
    repeat (16) @(posedge mclk);
    #2 rst = 0;
    tick(1);
    chk(output_enable, 1'b1);
    chk(bus_alert_out, 1'b0);
    chk(temp_limit, TEMP_LIMIT_RST);
    chk(track_cfg.ratio, TRACK_RATIO_RST);
    // Out of reset the block is an untracked master with soft-start in use.
    chk(use_softstart, 1'b1);
    chk(margin_cfg,
        {MARGIN_PCT_RST, MARGIN_PCT_RST, 1'b0, MARGIN_RATE_RST});
    chk(margin_active, MGN_NOMINAL);
    short_req = 1;
    wait_for(0, 1'b0, 4);
    chk(bus_alert_out, 1'b1);
    short_req = 0;
    wait_for(0, 1'b1, 4);
    pulse(alert_clear);
    chk(bus_alert_out, 1'b0);
    oc_cfg = '{RESP_IGNORE, 4'h0};
    short_req = 1;
    tick(20);
    chk(output_enable, 1'b1);
    oc_cfg = '{RESP_DELAY_OFF, 4'h0};
    tick(RUNON_DELAY_CYC - 20);
    chk(output_enable, 1'b1);
    wait_for(1, 1'b1, 60);
    chk(output_enable, 1'b0);
    short_req = 0;
    tick(2);
    pulse(restart_cmd);
    wait_for(0, 1'b1, 4);
    oc_cfg = '{RESP_RETRY_COUNT, 4'h2};
    short_req = 1;
    wait_for(0, 1'b0, 4);
    tick(2 * RETRY_DELAY_CYC - 100);
    chk(oc_latched_off, 1'b0);
    wait_for(1, 1'b1, 2 * RETRY_DELAY_CYC);
    short_req = 0;
    tick(100);
    chk(output_enable, 1'b0);
    pulse(restart_cmd);
    wait_for(0, 1'b1, 4);
    oc_cfg = '{RESP_RETRY_FOREVER, 4'h0};
    short_req = 1;
    tick(3 * RETRY_DELAY_CYC);
    chk(oc_latched_off, 1'b0);
    chk(output_enable, 1'b0);
    short_req = 0;
    wait_for(0, 1'b1, RETRY_DELAY_CYC + 10);
    oc_cfg = '{RESP_SHUTDOWN, 4'h0};
    ot_cfg = '{RESP_RETRY_FOREVER, 4'h0};
    temp_limit_in = 9'sh064;
    pulse(temp_limit_wr);
    chk(temp_limit, 9'sh064);
    temp_req = 9'sh064;
    tick(5);
    chk(output_enable, 1'b1);
    temp_req = 9'sh065;
    wait_for(0, 1'b0, 4);
    temp_req = 9'sh05A;
    tick(2 * RETRY_DELAY_CYC + 10);
    chk(output_enable, 1'b0);
    temp_req = 9'sh055;
    wait_for(0, 1'b1, RETRY_DELAY_CYC + 10);
    ot_cfg = '{RESP_SHUTDOWN, 4'h0};
    temp_req = 9'sh065;
    wait_for(0, 1'b0, 4);
    temp_req = 9'sh046;
    wait_for(0, 1'b1, RETRY_DELAY_CYC + 10);
    ot_cfg = '{RESP_DELAY_OFF, 4'h0};
    temp_req = 9'sh065;
    tick(RUNON_DELAY_CYC + 10);
    chk(ot_latched_off, 1'b1);
    chk(output_enable, 1'b0);
    temp_req = 9'sh046;
    pulse(restart_cmd);
    chk(ot_latched_off, 1'b0);
    tick(2);
    chk(output_enable, 1'b1);
    for (int c = 0; c < 8; c++) begin
      ss_strap_code = c[2:0];
      tick(2);
      chk(track_cfg.ratio,
          c[2] ? TRACK_RATIO_HALF : TRACK_RATIO_FULL);
      chk(track_cfg.ratiometric, c[2]);
      chk({track_cfg.limit_by_ref, track_cfg.follow_always}, c[1:0]);
    end
    pulse(track_cfg_wr);
    tick(1);
    chk(track_cfg, track_cfg_in);
    chk(use_softstart, 1'b0);
    margin_select = 2'h2;
    tick(1);
    chk(margin_active, MGN_HIGH);
    margin_select = 2'h1;
    tick(1);
    chk(margin_active, MGN_LOW);
    margin_select = 2'h2;
    margin_cmd_in = MGN_LOW;
    tick(1);
    pulse(margin_cmd_wr);
    tick(1);
    chk(margin_active, MGN_LOW);
    pulse(margin_cmd_release);
    tick(1);
    chk(margin_active, MGN_HIGH);
    pulse(margin_limit_wr);
    tick(1);
    chk(margin_cfg, {MARGIN_PCT_MAX, 5'h03, 1'b0, 8'h07});
    chk(margin_active, MGN_HIGH);
    stop_test;
  end
endmodule // fault_response_track_margin_ctl_bench
`default_nettype wire
